// ---- hw/pvmpf_formatter.sv ----
// Purpose: Builds instruction vector and message packets for the host
// Assumes: Decoder inputs are synchronous; packets leave through a buffer
// Notes:   A clean long-address vector is followed by one filler message packet
`default_nettype none
module pvmpf_formatter
  import pvmpf_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Vector words from decoder
  input  wire logic             vecValid,
  input  wire pvmpf_vec_t       vecWord,
  // Message words from decoder
  input  wire logic             msgValid,
  input  wire pvmpf_msg_t       msgWord,
  // Accept strobe back to decoder
  output logic                  coreReady,
  // Packet stream to host
  output logic                  pktValid,
  input  wire logic             pktReady,
  output logic [PKT_W-1:0]      pktData,
  // Status
  output logic                  msgDropped
);
  typedef enum logic [1:0] {
    PV_IDLE   = 2'b00,
    PV_FILLER = 2'b01
  } pvmpf_state_t;

  pvmpf_state_t     state;
  logic             msgOpen;
  logic [6:0]       fillPos;
  logic [1:0]       fillPhase;
  logic             bufReady;
  logic             bufValid;
  logic [PKT_W-1:0] bufData;
  logic             encValid;
  logic [PKT_W-1:0] encData;
  logic [PKT_W-1:0] next_vecPkt;
  logic [PKT_W-1:0] next_msgPkt;
  logic [PKT_W-1:0] next_fillPkt;
  logic             takeVec;
  logic             takeMsg;
  logic             encRoom;
  logic             encWants;
  logic             outLoad;
  logic             bufRd;
  logic             next_encBusy;
  logic             next_bufFull;

  // Decoder word is taken only while coreReady is high
  assign takeVec = coreReady && vecValid && (state == PV_IDLE);
  assign takeMsg = coreReady && msgValid && !vecValid && (state == PV_IDLE);

  // Encoder room now and one cycle ahead; coreReady must never promise room that a stall takes away
  assign encRoom      = !encValid || bufReady;
  assign encWants     = (state == PV_FILLER) || takeVec || (takeMsg && msgOpen);
  assign outLoad      = !pktValid || pktReady;
  assign bufRd        = bufValid && outLoad;
  assign next_encBusy = (encValid && !bufReady) || (encRoom && encWants);
  assign next_bufFull = !bufRd && (!bufReady || (bufValid && encValid));

  // Vector packet assembly; unused bits are left zero for the host to skip
  always_comb
  begin
    next_vecPkt                       = PKT_RST;
    next_vecPkt[TOP_BIT]              = 1'b0;
    next_vecPkt[POS_LSB +: POS_W]     = vecWord.pos;
    next_vecPkt[ERR_BIT]              = vecWord.err;
    next_vecPkt[PH_LSB +: 2]          = vecWord.phase;
    next_vecPkt[VT_LSB +: 3]          = VT_INSTR;
    next_vecPkt[IT_LSB +: 3]          = vecWord.instr;
    if (vecWord.instr == IT_TEMPADDR)
      next_vecPkt[DAT_LSB +: DATA_W]  = {vecWord.tempAddr, vecWord.frameNum};
    else
      next_vecPkt[DAT_LSB +: DATA_W]  = vecWord.rawData;
  end

  // Message packet assembly
  always_comb
  begin
    next_msgPkt                       = PKT_RST;
    next_msgPkt[TOP_BIT]              = 1'b0;
    next_msgPkt[POS_LSB +: POS_W]     = msgWord.pos;
    next_msgPkt[ERR_BIT]              = msgWord.err;
    next_msgPkt[PH_LSB +: 2]          = msgWord.phase;
    next_msgPkt[0 +: INFO_W]          = msgWord.info;
  end

  // Filler packet: next word position, information bits zero
  always_comb
  begin
    next_fillPkt                      = PKT_RST;
    next_fillPkt[POS_LSB +: POS_W]    = fillPos;
    next_fillPkt[PH_LSB +: 2]         = fillPhase;
  end

  // Sequencer: filler packet follows a clean long-address vector directly
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state     <= PV_IDLE;
      fillPos   <= 7'h00;
      fillPhase <= 2'h0;
    end
    else
    begin
      unique case (state)
        PV_IDLE:
        begin
          if (takeVec && vecWord.longAddr && !vecWord.err)
          begin
            state     <= PV_FILLER;
            fillPos   <= 7'(vecWord.pos + 7'h01);
            fillPhase <= vecWord.phase;
          end
        end
        PV_FILLER:
        begin
          if (encRoom) // Leave only when the filler is really loaded, else it is lost
            state <= PV_IDLE;
        end
        default:
          state <= PV_IDLE;
      endcase
    end
  end

  // Message gate: opened by a clean vector that announces message words
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      msgOpen <= 1'b0;
    else if (takeVec)
      msgOpen <= !vecWord.err && vecWord.hasMsg;
  end

  // Dropped message words are flagged for one cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      msgDropped <= 1'b0;
    else
      msgDropped <= takeMsg && !msgOpen;
  end

  // Encoder register in front of the buffer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      encValid <= 1'b0;
      encData  <= PKT_RST;
    end
    else if (encRoom)
    begin
      encValid <= 1'b0;
      if (state == PV_FILLER)
      begin
        encValid <= 1'b1;
        encData  <= next_fillPkt;
      end
      else if (takeVec)
      begin
        encValid <= 1'b1;
        encData  <= next_vecPkt;
      end
      else if (takeMsg && msgOpen)
      begin
        encValid <= 1'b1;
        encData  <= next_msgPkt;
      end
    end
  end

  // Back-pressure to the decoder; registered so it comes from a flip-flop
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      coreReady <= 1'b0;
    else
      coreReady <= (state == PV_IDLE) && !takeVec && !(next_encBusy && next_bufFull);
  end

  pvmpf_skid #(
    .WIDTH    (PKT_W)
  ) u_skid (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (encValid),
    .inReady  (bufReady),
    .inData   (encData),
    .outValid (bufValid),
    .outReady (outLoad),
    .outData  (bufData)
  );

  // Output stage straight from flip-flops
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pktValid <= 1'b0;
      pktData  <= PKT_RST;
    end
    else if (!pktValid || pktReady)
    begin
      pktValid <= bufValid;
      pktData  <= bufData;
    end
  end

  // Buffer is read exactly when the output stage loads, so an idle output never duplicates a word

  chk_vec_type: assert property (@(posedge clk) disable iff (sys_rst)
    takeVec |=> encValid && encData[VT_LSB +: 3] == 3'h1 && encData[TOP_BIT] == 1'b0)
    else $error("vector type not 001");
  chk_vec_pos: assert property (@(posedge clk) disable iff (sys_rst)
    takeVec |=> encData[POS_LSB +: POS_W] == $past(vecWord.pos))
    else $error("vector position wrong");
  chk_vec_err: assert property (@(posedge clk) disable iff (sys_rst)
    takeVec |=> encData[ERR_BIT] == $past(vecWord.err))
    else $error("vector error flag wrong");
  chk_vec_phase: assert property (@(posedge clk) disable iff (sys_rst)
    takeVec |=> encData[PH_LSB +: 2] == $past(vecWord.phase))
    else $error("vector phase wrong");
  chk_temp_addr: assert property (@(posedge clk) disable iff (sys_rst)
    takeVec && vecWord.instr == 3'h0 |=> encData[13:10] == $past(vecWord.tempAddr)
      && encData[9:3] == $past(vecWord.frameNum))
    else $error("temporary address fields wrong");
  chk_filler_next: assert property (@(posedge clk) disable iff (sys_rst)
    takeVec && vecWord.longAddr && !vecWord.err |=> state == PV_FILLER)
    else $error("filler state not entered");
  chk_filler_load: assert property (@(posedge clk) disable iff (sys_rst)
    state == PV_FILLER && encRoom |=> encValid && encData[20:0] == 21'h000000 && encData[ERR_BIT] == 1'b0
      && encData[POS_LSB +: POS_W] == $past(fillPos) && state == PV_IDLE)
    else $error("filler packet missing");
  chk_msg_gate: assert property (@(posedge clk) disable iff (sys_rst)
    takeMsg && !msgOpen |=> msgDropped)
    else $error("ungated message accepted");
  chk_msg_info: assert property (@(posedge clk) disable iff (sys_rst)
    takeMsg && msgOpen |=> encData[20:0] == $past(msgWord.info) && encData[ERR_BIT] == $past(msgWord.err)
      && encData[PH_LSB +: 2] == $past(msgWord.phase) && encData[POS_LSB +: POS_W] == $past(msgWord.pos))
    else $error("message packet fields wrong");
  chk_take_room: assert property (@(posedge clk) disable iff (sys_rst)
    (takeVec || takeMsg) |-> encRoom)
    else $error("word taken with encoder full");
  chk_out_hold: assert property (@(posedge clk) disable iff (sys_rst)
    pktValid && !pktReady |=> pktValid && $stable(pktData))
    else $error("packet changed while stalled");
endmodule : pvmpf_formatter
`default_nettype wire

// ---- hw/pvmpf_pkg.sv ----
// Purpose: Shared constants and types for the paging packet formatter
// Assumes: 32-bit packets, byte 3 is the most significant byte
// Notes:   Field positions are bit indices within the 32-bit packet, except TA_LSB, which is within the data field
`default_nettype none
package pvmpf_pkg;
  localparam int unsigned PKT_W      = 32;
  localparam int unsigned POS_W      = 7;
  localparam int unsigned INFO_W     = 21;
  localparam int unsigned DATA_W     = 11;
  // Vector type codes
  localparam logic [2:0] VT_SECURE   = 3'h0;
  localparam logic [2:0] VT_INSTR    = 3'h1;
  localparam logic [2:0] VT_SHORT    = 3'h2;
  localparam logic [2:0] VT_ALPHA    = 3'h5;
  localparam logic [2:0] VT_HEX      = 3'h6;
  // Instruction types
  localparam logic [2:0] IT_TEMPADDR = 3'h0;
  localparam logic [2:0] IT_TEST     = 3'h7;
  // Word position limits
  localparam logic [6:0] VEC_POS_MIN = 7'h02;
  localparam logic [6:0] MSG_POS_MIN = 7'h03;
  localparam logic [6:0] POS_MAX     = 7'h57;
  // Field positions
  localparam int unsigned TOP_BIT    = 31;
  localparam int unsigned POS_LSB    = 24;
  localparam int unsigned ERR_BIT    = 23;
  localparam int unsigned PH_LSB     = 21;
  localparam int unsigned VT_LSB     = 16;
  localparam int unsigned DAT_LSB    = 3;
  localparam int unsigned IT_LSB     = 0;
  localparam int unsigned TA_LSB     = 7;
  localparam logic [PKT_W-1:0] PKT_RST = 32'h0000_0000;

  // Decoded vector word from the decoder core
  typedef struct packed {
    logic [6:0]  pos;
    logic [1:0]  phase;
    logic        err;
    logic        longAddr;
    logic        hasMsg;
    logic [2:0]  instr;
    logic [3:0]  tempAddr;
    logic [6:0]  frameNum;
    logic [10:0] rawData;
  } pvmpf_vec_t;

  // Decoded message word from the decoder core
  typedef struct packed {
    logic [6:0]  pos;
    logic [1:0]  phase;
    logic        err;
    logic [20:0] info;
  } pvmpf_msg_t;
endpackage : pvmpf_pkg
`default_nettype wire

// ---- hw/pvmpf_skid.sv ----
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Full throughput; a receiver stall loses no word
`default_nettype none
module pvmpf_skid
  import pvmpf_pkg::*;
#(
  parameter int unsigned WIDTH = 32
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Filling side
  input  wire logic             inValid,
  output var  logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side
  output var  logic             outValid,
  input  wire logic             outReady,
  output var  logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem [2];
  logic             wrPtr;
  logic             rdPtr;
  logic [1:0]       count;
  logic             doWr;
  logic             doRd;

  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;
  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData  = mem[rdPtr];

  // Storage
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else if (doWr)
      mem[wrPtr] <= inData;
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (doWr)
        wrPtr <= ~wrPtr;
      if (doRd)
        rdPtr <= ~rdPtr;
      count <= 2'(count + {1'b0, doWr} - {1'b0, doRd});
    end
  end

  chk_no_overfill: assert property (@(posedge clk) disable iff (sys_rst) count <= 2'h2)
    else $error("buffer count above two");
endmodule : pvmpf_skid
`default_nettype wire

// ---- test/pvmpf_host_model.sv ----
// Purpose: Host side that drains the packet stream
// Assumes: Seed is set once by the bench before reset ends
// Notes:   Stalling lets the two-entry buffer fill and refuse
`default_nettype none
module pvmpf_host_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Stall control from the bench
  input  wire logic stall,
  // Packet stream
  output var  logic pktReady
);
  timeunit 1ns;
  timeprecision 1ps;
  // Random ready drops while stalling, full rate otherwise
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pktReady <= 1'b0;
    else
      pktReady <= !stall || ($urandom % 3 == 0);
  end
endmodule : pvmpf_host_model
`default_nettype wire

// ---- test/pvmpf_formatter_tb.sv ----
// Purpose: Self-checking bench for the packet formatter
// Assumes: Decoder words are offered one at a time
// Notes:   Don't-care bits are masked out before comparing
`default_nettype none
module pvmpf_formatter_tb;
  import pvmpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk;
  logic             sys_rst;
  logic             vecValid;
  logic             msgValid;
  logic             coreReady;
  logic             pktValid;
  logic             pktReady;
  logic             msgDropped;
  logic             stall;
  logic             gate;
  logic [PKT_W-1:0] pktData;
  logic [PKT_W-1:0] expQ[$];
  logic [PKT_W-1:0] mskQ[$];
  logic [63:0]      rnd;
  pvmpf_vec_t       vecWord;
  pvmpf_msg_t       msgWord;
  pvmpf_vec_t       vecDrv;
  pvmpf_msg_t       msgDrv;
  int               failures;
  int               checks;
  int               drops;
  int               expDrops;

  pvmpf_formatter uut (.clk(clk), .sys_rst(sys_rst), .vecValid(vecValid), .vecWord(vecDrv),
    .msgValid(msgValid), .msgWord(msgDrv), .coreReady(coreReady), .pktValid(pktValid),
    .pktReady(pktReady), .pktData(pktData), .msgDropped(msgDropped));
  pvmpf_host_model host (.clk(clk), .sys_rst(sys_rst), .stall(stall), .pktReady(pktReady));

  // Free-running clock, 20 ns period
  always #10 clk = ~clk;

  task summarize;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task chkPkt(input logic [PKT_W-1:0] got, input logic [PKT_W-1:0] exp, input logic [PKT_W-1:0] msk);
    checks++;
    if ((got & msk) !== (exp & msk))
    begin
      failures++;
      $display("Error %0t: packet %h expected %h", $time, got, exp);
    end
  endtask : chkPkt

  task chkCnt(input int got, input int exp);
    checks++;
    if (got != exp)
    begin
      failures++;
      $display("Error %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chkCnt

  // Hold the offer until an edge with coreReady high, bounded
  task offer(input logic isVec);
    int n;
    @(posedge clk);
    vecDrv   <= vecWord;
    msgDrv   <= msgWord;
    vecValid <= isVec;
    msgValid <= !isVec;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (coreReady !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      failures++;
      $display("Error %0t: word never taken", $time);
      summarize();
    end
    @(posedge clk);
    vecValid <= 1'b0;
    msgValid <= 1'b0;
  endtask : offer

  function automatic logic [PKT_W-1:0] vecPkt(input pvmpf_vec_t v);
    logic [10:0] d;
    d = (v.instr == IT_TEMPADDR) ? {v.tempAddr, v.frameNum} : v.rawData;
    return {1'b0, v.pos, v.err, v.phase, 2'b00, VT_INSTR, 2'b00, d, v.instr};
  endfunction : vecPkt

  // Sample at the falling edge, where registered outputs have settled
  always @(negedge clk)
  begin
    if (msgDropped === 1'b1)
      drops++;
    if (pktValid === 1'b1 && pktReady === 1'b1)
    begin
      if (expQ.size() == 0)
      begin
        failures++;
        $display("Error %0t: unexpected packet %h", $time, pktData);
      end
      else
        chkPkt(pktData, expQ.pop_front(), mskQ.pop_front());
    end
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    vecValid = 1'b0;
    msgValid = 1'b0;
    vecWord = '0;
    msgWord = '0;
    vecDrv = '0;
    msgDrv = '0;
    stall = 1'b0;
    failures = 0;
    checks = 0;
    drops = 0;
    expDrops = 0;
    void'($urandom(32'h432F93A4));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // A message with no vector before it must be discarded
    msgWord <= pvmpf_msg_t'({7'h03, 24'h123456});
    offer(1'b0);
    expDrops++;
    for (int i = 0; i < 80; i++)
    begin
      rnd = {$urandom, $urandom};
      vecWord = pvmpf_vec_t'(rnd[36:0]);
      vecWord.pos = (i == 0) ? VEC_POS_MIN : (i == 1) ? POS_MAX : 7'(2 + $urandom % 86);
      vecWord.err = ($urandom % 4 == 0);
      if (i < 8)
        vecWord.instr = 3'(i);
      stall <= (i > 20 && i < 50);
      offer(1'b1);
      expQ.push_back(vecPkt(vecWord));
      mskQ.push_back(32'hFFE7_3FFF);
      // Clean long-address vector brings one filler, its info ignored
      if (vecWord.longAddr && !vecWord.err)
      begin
        expQ.push_back({1'b0, vecWord.pos + 7'h01, 1'b0, vecWord.phase, 21'h000000});
        mskQ.push_back(32'hFFE0_0000);
      end
      gate = !vecWord.err && vecWord.hasMsg;
      repeat ($urandom % 4)
      begin
        rnd = {$urandom, $urandom};
        msgWord = pvmpf_msg_t'(rnd[30:0]);
        msgWord.pos = (i == 2) ? MSG_POS_MIN : 7'(3 + $urandom % 85);
        offer(1'b0);
        if (gate)
        begin
          expQ.push_back({1'b0, msgWord.pos, msgWord.err, msgWord.phase, msgWord.info});
          mskQ.push_back(32'hFFFF_FFFF);
        end
        else
          expDrops++;
      end
    end
    stall <= 1'b0;
    for (int n = 0; n < 500 && expQ.size() > 0; n++)
      @(posedge clk);
    if (expQ.size() > 0)
    begin
      failures++;
      $display("Error %0t: %0d packets never arrived", $time, expQ.size());
    end
    repeat (4) @(posedge clk);
    chkCnt(drops, expDrops);
    summarize();
  end
endmodule : pvmpf_formatter_tb
`default_nettype wire
